// file: verilog/fsrp_regs.svh
// constants for the fuse security and register preload block
`ifndef FSRP_REGS_SVH
`define FSRP_REGS_SVH
`define FSRP_NUM_CELLS        10
`define FSRP_FUSES_LEGACY_A   14'h383A
`define FSRP_FUSES_LEGACY_B   14'h3863
`define FSRP_FUSES_NATIVE     14'h38A8
`define FSRP_FUSE_ADDR_W      14
`define FSRP_SIG_ROW_W        64
`define FSRP_REG_RST          10'h000
`endif

// file: verilog/fsrp_pkg.sv
// types for the fuse security and register preload block
package fsrp_pkg;
	typedef enum logic [1:0]
	{
		FSRP_MODE_NATIVE   = 2'b00,
		FSRP_MODE_LEGACY_A = 2'b01,
		FSRP_MODE_LEGACY_B = 2'b10
	} fsrp_mode_t;

	typedef enum logic [1:0]
	{
		FSRP_ST_NORMAL  = 2'b00,
		FSRP_ST_PRELOAD = 2'b01,
		FSRP_ST_CAPTURE = 2'b10
	} fsrp_state_t;
endpackage

// file: verilog/fsrp_verify_mask.sv
// verify read path with security masking
`timescale 1ns/100ps
`default_nettype none
module fsrp_verify_mask
	import fsrp_pkg::*;
(
	input  wire logic sys_clk,     // system clock
	input  wire logic sys_rst,     // sync reset, active high
	input  wire logic clk_en,      // freezes state when low
	input  wire logic secured,     // security fuse programmed
	input  wire logic fuse_bit,    // raw fuse value at address
	input  wire logic verify_req,  // verify read strobe
	output logic      verify_data, // masked read data
	output logic      verify_vld   // read data valid
);
	logic nxt_data;
	logic nxt_vld;
	logic data_ff;
	logic vld_ff;

	always_comb
	begin
		nxt_data = data_ff;
		nxt_vld  = 1'b0;
		if (verify_req)
		begin
			// secured device reads every fuse as programmed [RQ1]
			nxt_data = secured ? 1'b1 : fuse_bit;
			nxt_vld  = 1'b1;
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
		begin
			data_ff <= 1'b0;
			vld_ff  <= 1'b0;
		end
		else if (clk_en)
		begin
			data_ff <= nxt_data;
			vld_ff  <= nxt_vld;
		end
	end

	assign verify_data = data_ff;
	assign verify_vld  = vld_ff;

	a_verify_masked: assert property (@(posedge sys_clk) disable iff (sys_rst) // [RQ1]
		(verify_req && secured && clk_en) |=> (verify_vld && verify_data))
	else $error("secured verify returned an erased fuse");
endmodule // fsrp_verify_mask
`default_nettype wire

// file: verilog/fsrp_top.sv
// preload capture and fuse array access for the paired output-cell registers
`timescale 1ns/100ps
`default_nettype none
`include "fsrp_regs.svh"
//Contract
//RQ1: once security fuse is set, every verified fuse reads as programmed.
//RQ2: programmer should set the security fuse last; masking is immediate.
//RQ3: each register can be forced high or low independent of its clock.
//RQ4: preload pin high loads one, low loads zero, polarity ignored.
//RQ5: tester holds elevated voltage on one input for whole preload.
//RQ6: clock term pulse captures I/O pin values into the selected register.
//RQ7: select low writes register 0 only; select high writes register 1 only.
//RQ8: legacy modes use legacy fuse counts, zero signature row, bus-hold off.
//RQ9: native mode uses full fuse count, signature row and bus-hold as given.
//RQ10: legacy modes keep checksum equal to legacy fuse file checksum.
//RQ11: without elevated voltage the preload path is ignored.
module fsrp_top
	import fsrp_pkg::*;
(
	input  wire logic                          sys_clk,        // system clock, 40 MHz
	input  wire logic                          sys_rst,        // sync reset, active high
	input  wire logic                          clk_en,         // freezes all state when low
	input  wire logic                          hv_detect,      // elevated voltage present on preload pin
	input  wire logic                          preload_clk,    // clock term pulse during preload
	input  wire logic                          preload_sel,    // 0 selects register 0, 1 register 1
	input  wire logic [`FSRP_NUM_CELLS-1:0]    io_pin_in,      // I/O pin levels
	input  wire logic [`FSRP_NUM_CELLS-1:0]    norm_d0,        // normal next value, register 0
	input  wire logic [`FSRP_NUM_CELLS-1:0]    norm_d1,        // normal next value, register 1
	input  wire logic [`FSRP_NUM_CELLS-1:0]    norm_clk0,      // normal clock term, register 0
	input  wire logic [`FSRP_NUM_CELLS-1:0]    norm_clk1,      // normal clock term, register 1
	input  wire logic [`FSRP_NUM_CELLS-1:0]    ar0,            // async reset term, register 0
	input  wire logic [`FSRP_NUM_CELLS-1:0]    ar1,            // async reset term, register 1
	input  wire logic                          sync_preset,    // common synchronous preset
	input  wire logic [1:0]                    prog_mode,      // programming mode
	input  wire logic                          prog_we,        // fuse write strobe
	input  wire logic [`FSRP_FUSE_ADDR_W-1:0]  fuse_addr,      // fuse address
	input  wire logic                          fuse_wdata,     // fuse write value
	input  wire logic                          sec_program,    // program security fuse
	input  wire logic                          verify_req,     // verify read strobe
	output logic [`FSRP_NUM_CELLS-1:0]         reg0_q,         // register 0 of each cell
	output logic [`FSRP_NUM_CELLS-1:0]         reg1_q,         // register 1 of each cell
	output logic                               preload_active, // preload state entered
	output logic                               secured,        // security fuse programmed
	output logic                               verify_data,    // masked verify data
	output logic                               verify_vld,     // verify data valid
	output logic                               addr_err,       // write outside mode fuse count
	output logic                               bus_hold_en     // bus-hold enable fuse
);
	localparam int NC = `FSRP_NUM_CELLS;
	localparam logic [`FSRP_FUSE_ADDR_W-1:0] SIG_BASE = `FSRP_FUSES_NATIVE - 14'h0041;
	localparam logic [`FSRP_FUSE_ADDR_W-1:0] HOLD_ADDR = `FSRP_FUSES_NATIVE - 14'h0001;

	fsrp_state_t         state_ff;
	fsrp_state_t         nxt_state;
	logic [NC-1:0]       r0_ff;
	logic [NC-1:0]       r1_ff;
	logic [NC-1:0]       nxt_r0;
	logic [NC-1:0]       nxt_r1;
	logic                pclk_ff;
	logic                sec_ff;
	logic                nxt_sec;
	logic                err_ff;
	logic                nxt_err;
	logic                hold_ff;
	logic                nxt_hold;
	logic                pl_ff;
	logic [`FSRP_NUM_CELLS*2-1:0] fuses [0:(1<<`FSRP_FUSE_ADDR_W)-1];
	logic                fuse_rd;
	logic [`FSRP_FUSE_ADDR_W-1:0] limit;
	logic                legacy;
	logic                pulse;
	logic                fuse_wval;

	assign pulse  = preload_clk & ~pclk_ff;
	assign legacy = (prog_mode == FSRP_MODE_LEGACY_A) || (prog_mode == FSRP_MODE_LEGACY_B);

	always_comb
	begin
		// fuse count accepted per mode [RQ8] [RQ9]
		if (prog_mode == FSRP_MODE_LEGACY_A)
			limit = `FSRP_FUSES_LEGACY_A;
		else if (prog_mode == FSRP_MODE_LEGACY_B)
			limit = `FSRP_FUSES_LEGACY_B;
		else
			limit = `FSRP_FUSES_NATIVE;
	end

	always_comb
	begin
		nxt_state = state_ff;
		case (state_ff)
			FSRP_ST_NORMAL:  if (hv_detect) nxt_state = FSRP_ST_PRELOAD;
			FSRP_ST_PRELOAD: if (!hv_detect) nxt_state = FSRP_ST_NORMAL;
				else if (pulse) nxt_state = FSRP_ST_CAPTURE;
			FSRP_ST_CAPTURE: nxt_state = hv_detect ? FSRP_ST_PRELOAD : FSRP_ST_NORMAL;
			default:         nxt_state = FSRP_ST_NORMAL;
		endcase
	end

	// per-cell register pair; preload overrides the normal terms
	genvar gi;
	generate
		for (gi = 0; gi < NC; gi++)
		begin : g_cell
			always_comb
			begin
				nxt_r0[gi] = r0_ff[gi];
				nxt_r1[gi] = r1_ff[gi];
				if (hv_detect && state_ff == FSRP_ST_PRELOAD && pulse)
				begin
					// raw pin level, output polarity plays no part [RQ3] [RQ4] [RQ6] [RQ7]
					if (!preload_sel)
						nxt_r0[gi] = io_pin_in[gi];
					else
						nxt_r1[gi] = io_pin_in[gi];
				end
				else if (!hv_detect)
				begin
					// only normal terms reach the registers here [RQ11]
					if (ar0[gi])
						nxt_r0[gi] = 1'b0;
					else if (norm_clk0[gi])
						nxt_r0[gi] = sync_preset | norm_d0[gi];
					if (ar1[gi])
						nxt_r1[gi] = 1'b0;
					else if (norm_clk1[gi])
						nxt_r1[gi] = sync_preset | norm_d1[gi];
				end
			end
		end
	endgenerate

	always_comb
	begin
		nxt_sec  = sec_ff | sec_program;
		nxt_err  = 1'b0;
		nxt_hold = hold_ff;
		fuse_wval = fuse_wdata;
		if (prog_we)
		begin
			if (fuse_addr >= limit)
				nxt_err = 1'b1;
			if (legacy && fuse_addr >= SIG_BASE)
				fuse_wval = 1'b0; // signature row zero, bus-hold off in legacy [RQ8] [RQ10]
			if (fuse_addr == HOLD_ADDR)
				nxt_hold = legacy ? 1'b0 : fuse_wdata; // [RQ9]
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
		begin
			state_ff <= FSRP_ST_NORMAL;
			r0_ff    <= `FSRP_REG_RST;
			r1_ff    <= `FSRP_REG_RST;
			pclk_ff  <= 1'b0;
			sec_ff   <= 1'b0;
			err_ff   <= 1'b0;
			hold_ff  <= 1'b0;
			pl_ff    <= 1'b0;
		end
		else if (clk_en)
		begin
			state_ff <= nxt_state;
			r0_ff    <= nxt_r0;
			r1_ff    <= nxt_r1;
			pclk_ff  <= preload_clk;
			sec_ff   <= nxt_sec;
			err_ff   <= nxt_err;
			hold_ff  <= nxt_hold;
			pl_ff    <= hv_detect;
		end
	end

	// fuse array, kept as one bit per entry in the low lane
	always_ff @(posedge sys_clk)
	begin
		if (clk_en && prog_we && fuse_addr < limit)
			fuses[fuse_addr] <= {19'h00000, fuse_wval};
	end
	assign fuse_rd = fuses[fuse_addr][0];

	// security mask applies the same cycle it is set, hence program it last [RQ2]
	fsrp_verify_mask u_verify
	(
		.sys_clk     (sys_clk),
		.sys_rst     (sys_rst),
		.clk_en      (clk_en),
		.secured     (nxt_sec),
		.fuse_bit    (fuse_rd),
		.verify_req  (verify_req),
		.verify_data (verify_data),
		.verify_vld  (verify_vld)
	);

	assign reg0_q         = r0_ff;
	assign reg1_q         = r1_ff;
	assign preload_active = pl_ff; // [RQ5]
	assign secured        = sec_ff;
	assign addr_err       = err_ff;
	assign bus_hold_en    = hold_ff;

	sequence s_preload_sel0;
		hv_detect && state_ff == FSRP_ST_PRELOAD && pulse && !preload_sel && clk_en;
	endsequence

	a_preload_reg0: assert property (@(posedge sys_clk) disable iff (sys_rst) // [RQ7]
		s_preload_sel0 |=> (reg0_q == $past(io_pin_in) && reg1_q == $past(reg1_q)))
	else $error("preload with select low misloaded");

	a_preload_reg1: assert property (@(posedge sys_clk) disable iff (sys_rst) // [RQ4]
		(hv_detect && state_ff == FSRP_ST_PRELOAD && pulse && preload_sel && clk_en)
		|=> (reg1_q == $past(io_pin_in) && reg0_q == $past(reg0_q)))
	else $error("preload with select high misloaded");

	a_no_hv_ignore: assert property (@(posedge sys_clk) disable iff (sys_rst) // [RQ11]
		(!hv_detect && clk_en && ar0 == '0 && norm_clk0 == '0) |=> reg0_q == $past(reg0_q))
	else $error("register changed without a normal term");

	a_legacy_hold: assert property (@(posedge sys_clk) disable iff (sys_rst) // [RQ8]
		(prog_we && legacy && clk_en && fuse_addr == HOLD_ADDR) |=> !bus_hold_en)
	else $error("bus-hold enabled in legacy mode");

	a_sec_sticky: assert property (@(posedge sys_clk) disable iff (sys_rst) // [RQ1]
		(sec_program && clk_en) |=> secured [*3])
	else $error("security fuse did not stay set");
endmodule // fsrp_top
`default_nettype wire

// file: dv/fsrp_tester.sv
// programmer and tester model driving the preload and fuse pins
`timescale 1ns/100ps
`default_nettype none
module fsrp_tester
(
	input  wire logic        sys_clk,     // system clock
	output logic             hv_detect,   // elevated preload voltage
	output logic             preload_clk, // clock term
	output logic             preload_sel, // register select
	output logic [9:0]       io_pin_in,   // pin levels
	output logic [1:0]       prog_mode,   // programming mode
	output logic             prog_we,     // fuse write strobe
	output logic [13:0]      fuse_addr,   // fuse address
	output logic             fuse_wdata,  // fuse value
	output logic             sec_program, // security fuse strobe
	output logic             verify_req   // verify strobe
);
	initial
	begin
		{hv_detect, preload_clk, preload_sel, prog_we, fuse_wdata, sec_program, verify_req} = 7'h00;
		{prog_mode, fuse_addr} = 16'h0000;
		io_pin_in = 10'h155;
	end
	task automatic preload(input logic hv, input logic sel, input logic [9:0] lvl);
		@(negedge sys_clk);
		hv_detect = hv; // held for the whole operation
		repeat (2) @(negedge sys_clk);
		preload_sel = sel;
		io_pin_in = lvl;
		preload_clk = 1'b1; // one capture pulse
		@(negedge sys_clk);
		preload_clk = 1'b0;
		io_pin_in = ~lvl; // pins no longer hold the forced level
		@(negedge sys_clk);
		hv_detect = 1'b0;
	endtask
	task automatic write(input logic [1:0] mode, input logic [13:0] a, input logic d);
		@(negedge sys_clk);
		prog_mode = mode; // mode sets fuse count and row handling
		fuse_addr = a;
		fuse_wdata = d;
		prog_we = 1'b1;
		@(negedge sys_clk);
		prog_we = 1'b0;
	endtask
	task automatic secure();
		@(negedge sys_clk);
		sec_program = 1'b1; // issued after all fuse writes
		@(negedge sys_clk);
		sec_program = 1'b0;
	endtask
	task automatic verify(input logic [13:0] a);
		@(negedge sys_clk);
		fuse_addr = a;
		verify_req = 1'b1;
		@(negedge sys_clk);
		verify_req = 1'b0;
	endtask
endmodule // fsrp_tester
`default_nettype wire

// file: dv/fsrp_top_tb.sv
// self-checking testbench for the preload and fuse access block
`timescale 1ns/100ps
`default_nettype none
`include "fsrp_regs.svh"
module fsrp_top_tb;
	import fsrp_pkg::*;
	logic                        sys_clk, sys_rst, clk_en, sync_preset;
	logic [`FSRP_NUM_CELLS-1:0]  norm_d0, norm_d1, norm_clk0, norm_clk1, ar0, ar1;
	wire logic                   hv_detect, preload_clk, preload_sel, prog_we, fuse_wdata, sec_program, verify_req;
	wire logic [9:0]             io_pin_in;
	wire logic [1:0]             prog_mode;
	wire logic [13:0]            fuse_addr;
	wire logic [9:0]             reg0_q, reg1_q;
	wire logic                   preload_active, secured, verify_data, verify_vld, addr_err, bus_hold_en;
	int                          n_errors = 0;
	int                          n_compared = 0;
	fsrp_tester fsrp_tester_inst (.sys_clk(sys_clk), .hv_detect(hv_detect), .preload_clk(preload_clk),
		.preload_sel(preload_sel), .io_pin_in(io_pin_in), .prog_mode(prog_mode), .prog_we(prog_we),
		.fuse_addr(fuse_addr), .fuse_wdata(fuse_wdata), .sec_program(sec_program), .verify_req(verify_req));
	fsrp_top fsrp_top_inst (.sys_clk(sys_clk), .sys_rst(sys_rst), .clk_en(clk_en), .hv_detect(hv_detect),
		.preload_clk(preload_clk), .preload_sel(preload_sel), .io_pin_in(io_pin_in), .norm_d0(norm_d0),
		.norm_d1(norm_d1), .norm_clk0(norm_clk0), .norm_clk1(norm_clk1), .ar0(ar0), .ar1(ar1),
		.sync_preset(sync_preset), .prog_mode(prog_mode), .prog_we(prog_we), .fuse_addr(fuse_addr),
		.fuse_wdata(fuse_wdata), .sec_program(sec_program), .verify_req(verify_req), .reg0_q(reg0_q),
		.reg1_q(reg1_q), .preload_active(preload_active), .secured(secured), .verify_data(verify_data),
		.verify_vld(verify_vld), .addr_err(addr_err), .bus_hold_en(bus_hold_en));
	initial
	begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wrap_up();
		$display("compared %0d, mismatches %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic t_preload();
		fsrp_tester_inst.preload(1'b1, 1'b0, 10'h2A5);
		check(reg0_q, 16'h02A5);
		check(reg1_q, 16'h0000);
		fsrp_tester_inst.preload(1'b1, 1'b1, 10'h15A);
		check(reg1_q, 16'h015A);
		check(reg0_q, 16'h02A5);
		$display("test preload done");
	endtask
	task automatic t_normal();
		fsrp_tester_inst.preload(1'b0, 1'b0, 10'h3FF);
		check(reg0_q, 16'h02A5);
		check(preload_active, 16'h0000);
		@(negedge sys_clk);
		norm_d0 = 10'h0F0;
		norm_clk0 = 10'h3FF;
		sync_preset = 1'b1;
		norm_clk1 = 10'h3FF;
		@(negedge sys_clk);
		{norm_clk0, norm_clk1, sync_preset} = 21'h00000;
		check(reg0_q, 16'h03FF);
		check(reg1_q, 16'h03FF);
		ar0 = 10'h00F;
		ar1 = 10'h0F0;
		@(negedge sys_clk);
		{ar0, ar1} = 20'h00000;
		check(reg0_q, 16'h03F0);
		check(reg1_q, 16'h030F);
		// without the preset the clock term loads the data term itself
		norm_clk0 = 10'h3FF;
		@(negedge sys_clk);
		check(reg0_q, 16'h00F0);
		// enable low must freeze the pair even with live clock and reset terms
		clk_en = 1'b0;
		norm_d0 = 10'h000;
		ar1 = 10'h3FF;
		@(negedge sys_clk);
		check(reg0_q, 16'h00F0);
		check(reg1_q, 16'h030F);
		clk_en = 1'b1;
		{norm_clk0, ar1} = 20'h00000;
		$display("test normal path done");
	endtask
	task automatic wr(input logic [1:0] m, input logic [13:0] a, input logic d, input logic err);
		fsrp_tester_inst.write(m, a, d);
		check(addr_err, {15'h0000, err});
	endtask
	task automatic t_modes();
		wr(2'h0, 14'd14503, 1'b1, 1'b0);
		check(bus_hold_en, 16'h0001);
		wr(2'h1, 14'd14503, 1'b1, 1'b1);
		check(bus_hold_en, 16'h0000);
		wr(2'h1, 14'h383A, 1'b1, 1'b1);
		wr(2'h1, 14'h3839, 1'b1, 1'b0);
		wr(2'h2, 14'h3863, 1'b1, 1'b1);
		wr(2'h2, 14'h3862, 1'b1, 1'b0);
		wr(2'h2, 14'd14440, 1'b1, 1'b1);
		wr(2'h0, 14'h38A8, 1'b1, 1'b1);
		wr(2'h0, 14'd14440, 1'b1, 1'b0);
		wr(2'h0, 14'h0005, 1'b0, 1'b0);
		$display("test modes done");
	endtask
	task automatic t_secure();
		fsrp_tester_inst.verify(14'd14440);
		check({verify_vld, verify_data}, 16'h0003);
		fsrp_tester_inst.verify(14'h0005);
		check({verify_vld, verify_data}, 16'h0002);
		check(secured, 16'h0000);
		fsrp_tester_inst.secure();
		check(secured, 16'h0001);
		fsrp_tester_inst.verify(14'h0005);
		check({verify_vld, verify_data}, 16'h0003);
		$display("test security done");
	endtask
	initial
	begin
		{sys_rst, clk_en, sync_preset} = 3'b110;
		{norm_d0, norm_d1, norm_clk0, norm_clk1, ar0, ar1} = 60'h0;
		repeat (3) @(posedge sys_clk);
		@(negedge sys_clk);
		sys_rst = 1'b0;
		t_preload();
		t_normal();
		t_modes();
		t_secure();
		wrap_up();
	end
	initial
	begin
		repeat (5000) @(posedge sys_clk);
		n_errors++;
		wrap_up();
	end
endmodule // fsrp_top_tb
`default_nettype wire
